// ==== verilog/dmx_pkg.sv ====
// Purpose: shared constants for the move/multiply execution block
// Assumes: 16-bit instruction words, 12-bit data addresses
// Notes:   quarter phases are counted 0..3 (Q1..Q4)
package dmx_pkg;
  localparam int unsigned DMX_CLK_HZ      = 20_000_000;
  localparam logic [3:0]  DMX_OP_MOVE1    = 4'hC;
  localparam logic [3:0]  DMX_OP_MOVE2    = 4'hF;
  localparam logic [7:0]  DMX_OP_BANKLIT  = 8'h01;
  localparam logic [7:0]  DMX_OP_WORKLIT  = 8'h0E;
  localparam logic [7:0]  DMX_OP_MULLIT   = 8'h0D;
  localparam logic [6:0]  DMX_OP_STORE    = 7'h37;
  localparam logic [1:0]  DMX_Q1          = 2'h0;
  localparam logic [1:0]  DMX_Q2          = 2'h1;
  localparam logic [1:0]  DMX_Q3          = 2'h2;
  localparam logic [1:0]  DMX_Q4          = 2'h3;
  localparam logic [7:0]  DMX_BSR_RST     = 8'h00;
  localparam logic [7:0]  DMX_W_RST       = 8'h00;
  localparam logic [7:0]  DMX_PROD_RST    = 8'h00;
  localparam logic [3:0]  DMX_ACCESS_HI   = 4'hF;
  localparam logic [7:0]  DMX_ACCESS_SPLIT = 8'h80;
  localparam int          DMX_STORE_ABIT  = 8;
  typedef enum logic [1:0] {DMX_FETCH, DMX_MOVE_WAIT, DMX_MOVE_DEST} dmx_state_t;
endpackage

// ==== verilog/dmx_mul.sv ====
// Purpose: unsigned 8x8 product for the literal multiply
// Assumes: purely combinational, settles within one quarter
// Notes:   no flags produced; product always fits 16 bits
`timescale 1ns/1ps
module dmx_mul
  import dmx_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0]   a,
  input  wire logic [WIDTH-1:0]   b,
  output logic      [2*WIDTH-1:0] p
);
  // RULE_12 no overflow detect
  always_comb begin
    p = (2*WIDTH)'(a) * (2*WIDTH)'(b);
  end
endmodule

// ==== verilog/dmx_core.sv ====
// Purpose: decode and execute move, literal load, store and multiply
// Assumes: instruction word held stable for the whole cycle
// Notes:   data memory is external, one write port and one read port
`timescale 1ns/1ps
// Behaviour
// RULE_01: two-word move, read first, write last Q4
// RULE_02: move copies source, source left unchanged
// RULE_03: bank literal load writes bank selector
// RULE_04: bank selector written in fourth quarter
// RULE_05: work literal load fills working register
// RULE_06: working register holds literal after Q4
// RULE_07: store copies working register to file
// RULE_08: bank bit zero uses access bank
// RULE_09: literal multiply unsigned, one cycle
// RULE_10: high byte high, low byte low
// RULE_11: multiply leaves working register, flags alone
// RULE_12: no overflow, carry or zero detection
// RULE_13: move addresses full twelve-bit space
// RULE_14: programs avoid counter and stack destinations
// RULE_15: second move word is operand only
module dmx_core
  import dmx_pkg::*;
#(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [15:0]   instr,
  input  wire logic [DW-1:0] mem_rdata,
  output logic      [AW-1:0] mem_raddr,
  output logic               mem_re,
  output logic      [AW-1:0] mem_waddr,
  output logic      [DW-1:0] mem_wdata,
  output logic               mem_we,
  output logic               cycle_end,
  output logic      [1:0]    quarter,
  output logic      [DW-1:0] work,
  output logic      [DW-1:0] bank_selector,
  output logic      [DW-1:0] product_high,
  output logic      [DW-1:0] product_low,
  output logic      [3:0]    status_flags
);
  logic [1:0]       q_q, q_d;
  dmx_state_t       st_q, st_d;
  logic [DW-1:0]    w_q, w_d, bsr_q, bsr_d, ph_q, ph_d, pl_q, pl_d;
  logic [DW-1:0]    src_q, src_d;
  logic [DW-1:0]    lit_q, lit_d;
  logic [2*DW-1:0]  prod;
  logic             is_move1, is_bank, is_work, is_mul, is_store;
  logic [AW-1:0]    store_addr;

  dmx_mul #(.WIDTH(DW)) u_mul (
    .a (w_q),
    .b (lit_q),
    .p (prod)
  );

  always_comb begin
    is_move1 = (st_q == DMX_FETCH) && (instr[15:12] == DMX_OP_MOVE1);
    is_bank  = (st_q == DMX_FETCH) && (instr[15:8] == DMX_OP_BANKLIT);
    is_work  = (st_q == DMX_FETCH) && (instr[15:8] == DMX_OP_WORKLIT);
    is_mul   = (st_q == DMX_FETCH) && (instr[15:8] == DMX_OP_MULLIT);
    is_store = (st_q == DMX_FETCH) && (instr[15:9] == DMX_OP_STORE);
    // RULE_08 access bank split
    if (instr[DMX_STORE_ABIT]) begin
      store_addr = {bsr_q[3:0], instr[7:0]};
    end else if (instr[7:0] < DMX_ACCESS_SPLIT) begin
      store_addr = {4'h0, instr[7:0]};
    end else begin
      store_addr = {DMX_ACCESS_HI, instr[7:0]};
    end
  end

  always_comb begin
    q_d   = q_q + 2'h1;
    st_d  = st_q;
    w_d   = w_q;
    bsr_d = bsr_q;
    ph_d  = ph_q;
    pl_d  = pl_q;
    src_d = src_q;
    lit_d = lit_q;
    mem_raddr = '0;
    mem_re    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    mem_we    = 1'b0;
    if (q_q == DMX_Q2) begin
      lit_d = instr[7:0];
    end
    case (st_q)
      DMX_FETCH: begin
        // RULE_01 source read in Q2
        // RULE_13 full 12-bit source
        if (is_move1 && q_q == DMX_Q2) begin
          mem_raddr = instr[AW-1:0];
          mem_re    = 1'b1;
          src_d     = mem_rdata;
        end
        if (q_q == DMX_Q4) begin
          if (is_move1) begin
            st_d = DMX_MOVE_DEST;
          end
          // RULE_03 bank literal write
          // RULE_04 written in Q4
          if (is_bank) begin
            bsr_d = lit_q;
          end
          // RULE_05 work literal write
          // RULE_06 literal in Q4
          if (is_work) begin
            w_d = lit_q;
          end
          // RULE_07 store working register
          if (is_store) begin
            mem_waddr = store_addr;
            mem_wdata = w_q;
            mem_we    = 1'b1;
          end
          // RULE_09 unsigned product
          // RULE_10 split high and low
          // RULE_11 work untouched
          if (is_mul) begin
            ph_d = prod[2*DW-1:DW];
            pl_d = prod[DW-1:0];
          end
        end
      end
      DMX_MOVE_DEST: begin
        // RULE_15 operand word only
        // RULE_02 copy latched source
        // RULE_14 destination trusted to program
        if (q_q == DMX_Q4) begin
          mem_waddr = instr[AW-1:0];
          mem_wdata = src_q;
          mem_we    = 1'b1;
          st_d      = DMX_FETCH;
        end
      end
      default: begin
        st_d = DMX_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_q   <= DMX_Q1;
      st_q  <= DMX_FETCH;
      w_q   <= DMX_W_RST;
      bsr_q <= DMX_BSR_RST;
      ph_q  <= DMX_PROD_RST;
      pl_q  <= DMX_PROD_RST;
      src_q <= DMX_W_RST;
      lit_q <= DMX_W_RST;
    end else begin
      q_q   <= q_d;
      st_q  <= st_d;
      w_q   <= w_d;
      bsr_q <= bsr_d;
      ph_q  <= ph_d;
      pl_q  <= pl_d;
      src_q <= src_d;
      lit_q <= lit_d;
    end
  end

  // flags never touched by this group
  assign status_flags  = 4'h0;
  assign cycle_end     = (q_q == DMX_Q4);
  assign quarter       = q_q;
  assign work          = w_q;
  assign bank_selector = bsr_q;
  assign product_high  = ph_q;
  assign product_low   = pl_q;

  a_move_dest_write: assert property (@(posedge clk) disable iff (rst) // RULE_01
    (st_q == DMX_MOVE_DEST && q_q == DMX_Q4) |-> mem_we)
    else $error("move destination write missing");
  a_move_no_read: assert property (@(posedge clk) disable iff (rst) // RULE_01
    (st_q == DMX_MOVE_DEST) |-> !mem_re)
    else $error("dummy read during move");
  a_move_copy: assert property (@(posedge clk) disable iff (rst) // RULE_02
    (st_q == DMX_FETCH && is_move1 && q_q == DMX_Q2) ##6 mem_we
      |-> mem_wdata == $past(mem_rdata, 6))
    else $error("move copied wrong value");
  a_bank_load: assert property (@(posedge clk) disable iff (rst) // RULE_04
    (is_bank && q_q == DMX_Q4) |=> bsr_q == $past(instr[7:0]))
    else $error("bank selector not loaded");
  a_work_load: assert property (@(posedge clk) disable iff (rst) // RULE_06
    (is_work && q_q == DMX_Q4) |=> w_q == $past(instr[7:0]))
    else $error("working register not loaded");
  a_store_data: assert property (@(posedge clk) disable iff (rst) // RULE_07
    (is_store && q_q == DMX_Q4) |-> mem_we && mem_wdata == w_q)
    else $error("store data wrong");
  a_store_access: assert property (@(posedge clk) disable iff (rst) // RULE_08
    (is_store && q_q == DMX_Q4 && !instr[8] && !instr[7])
      |-> mem_waddr[11:8] == 4'h0)
    else $error("access bank ignored");
  a_mul_result: assert property (@(posedge clk) disable iff (rst) // RULE_10
    (is_mul && q_q == DMX_Q4) |=> {ph_q, pl_q} ==
      16'($past(w_q)) * 16'($past(instr[7:0])))
    else $error("product wrong");
  a_mul_keeps_w: assert property (@(posedge clk) disable iff (rst) // RULE_11
    (is_mul && q_q == DMX_Q4) |=> $stable(w_q))
    else $error("multiply changed working register");
  a_move_src_read: assert property (@(posedge clk) disable iff (rst) // RULE_13
    (is_move1 && q_q == DMX_Q2) |-> mem_re && mem_raddr == instr[AW-1:0])
    else $error("move source not read in second quarter");
  a_store_banked: assert property (@(posedge clk) disable iff (rst) // RULE_08
    (is_store && q_q == DMX_Q4 && instr[8])
      |-> mem_waddr[11:8] == bank_selector[3:0] && mem_waddr[7:0] == instr[7:0])
    else $error("bank selector ignored on store");
  a_dest_operand: assert property (@(posedge clk) disable iff (rst) // RULE_15
    (st_q == DMX_MOVE_DEST && q_q == DMX_Q4)
      |=> $stable(w_q) && $stable(bsr_q) && $stable({ph_q, pl_q}))
    else $error("move operand word executed");
  c_move: cover property (@(posedge clk) st_q == DMX_MOVE_DEST && mem_we);
  c_mul: cover property (@(posedge clk) is_mul && q_q == DMX_Q4);
  c_store_bank: cover property (@(posedge clk) is_store && instr[8] && mem_we);
  c_bank: cover property (@(posedge clk) is_bank && q_q == DMX_Q4);
endmodule

// ==== tb/dmx_core_bench.sv ====
// Purpose: self-checking bench for the move/multiply execution block
// Assumes: bench owns the data memory, read comb, written on we edges
// Notes:   words issued only at a cycle boundary so none repeats
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module dmx_core_bench
  import dmx_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [15:0] instr;
  logic [11:0] mem_raddr;
  logic [11:0] mem_waddr;
  logic [7:0]  mem_wdata;
  logic        mem_re;
  logic        mem_we;
  logic        cycle_end;
  logic [1:0]  quarter;
  logic [7:0]  work;
  logic [7:0]  bank_selector;
  logic [7:0]  product_high;
  logic [7:0]  product_low;
  logic [3:0]  status_flags;
  logic [7:0]  mem [0:4095];
  logic [15:0] we_word;
  logic [15:0] re_word;
  int          fails;
  int          n_tests;
  int          n_wr;

  dmx_core dut (.clk(clk), .rst(rst), .instr(instr),
    .mem_rdata(mem[mem_raddr]), .mem_raddr(mem_raddr), .mem_re(mem_re),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .cycle_end(cycle_end), .quarter(quarter), .work(work),
    .bank_selector(bank_selector), .product_high(product_high),
    .product_low(product_low), .status_flags(status_flags));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // write port lands in memory; flags must never move
  always @(posedge clk) begin
    if (!rst) `CHK(status_flags, 4'h0)
    if (mem_re === 1'b1) begin
      `CHK(quarter, DMX_Q2)
      re_word <= instr;
    end
    if (mem_we === 1'b1) begin
      `CHK(quarter, DMX_Q4)
      `CHK(cycle_end, 1'b1)
      mem[mem_waddr] <= mem_wdata;
      we_word <= instr;
      n_wr++;
    end
  end

  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for the last quarter of the running cycle
  task automatic wait_q4();
    int i;
    for (i = 0; i < 8 && quarter !== DMX_Q4; i++) begin
      @(posedge clk);
      #1;
    end
    if (quarter !== DMX_Q4) begin
      fails++;
      summarize();
    end
  endtask

  // issue n consecutive words, then idle word 0x0000 (a no-op)
  task automatic run(input logic [15:0] w1, input logic [15:0] w2, int n);
    wait_q4();
    @(posedge clk) instr <= w1;
    #1;
    if (n == 2) begin
      wait_q4();
      @(posedge clk) instr <= w2;
      #1;
    end
    wait_q4();
    @(posedge clk) instr <= 16'h0000;
    #1;
  endtask

  task automatic t_reset();
    `CHK(({work, bank_selector, product_high, product_low}), 32'h0)
    $display("test reset done");
  endtask

  task automatic t_lits();
    run(16'h0E5A, 16'h0, 1);
    `CHK(work, 8'h5A)
    run(16'h0102, 16'h0, 1);
    `CHK(bank_selector, 8'h02)
    run(16'h0105, 16'h0, 1);
    `CHK(bank_selector, 8'h05)
    `CHK(work, 8'h5A)
    $display("test literal loads done");
  endtask

  task automatic t_mul();
    run(16'h0EE2, 16'h0, 1);
    run(16'h0DC4, 16'h0, 1);
    `CHK(({product_high, product_low}), 16'hAD08)
    `CHK(work, 8'hE2)
    run(16'h0D00, 16'h0, 1);
    `CHK(({product_high, product_low}), 16'h0000)
    run(16'h0EFF, 16'h0, 1);
    run(16'h0DFF, 16'h0, 1);
    `CHK(({product_high, product_low}), 16'hFE01)
    $display("test multiply done");
  endtask

  task automatic t_store();
    run(16'h0E4F, 16'h0, 1);
    n_wr = 0;
    run(16'h6F20, 16'h0, 1);
    `CHK(mem[12'h520], 8'h4F)
    run(16'h6E20, 16'h0, 1);
    `CHK(mem[12'h020], 8'h4F)
    run(16'h6E90, 16'h0, 1);
    `CHK(mem[12'hF90], 8'h4F)
    `CHK(n_wr, 3)
    $display("test store done");
  endtask

  task automatic t_move();
    mem[12'hFFE] = 8'h33;
    mem[12'h001] = 8'h11;
    n_wr = 0;
    run(16'hCFFE, 16'hF001, 2);
    `CHK(mem[12'h001], 8'h33)
    `CHK(mem[12'hFFE], 8'h33)
    `CHK(n_wr, 1)
    `CHK(re_word, 16'hCFFE)
    `CHK(we_word, 16'hF001)
    `CHK(work, 8'h4F)
    $display("test move done");
  endtask

  initial begin
    rst = 1'b1;
    instr = 16'h0000;
    fails = 0;
    n_tests = 0;
    n_wr = 0;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_lits();
    t_mul();
    t_store();
    t_move();
    summarize();
  end
endmodule
